// ---- logic/jtag_tap_boundary_scan.sv ----
// Purpose: Test access port controller with instruction and data paths.
// Assumes: Test clock below a quarter of sys_clk rate.
// Notes: All test pins sampled through two flip-flops on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_boundary_scan
	import jtag_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Test pins
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	input  wire logic                  trst_n,
	output logic                       tdo,
	output logic                       tdo_oe,
	// Core and pad side of the boundary cells
	input  wire logic [PIN_COUNT-1:0]  pin_in,
	input  wire logic [PIN_COUNT-1:0]  core_out,
	input  wire logic [PIN_COUNT-1:0]  core_oe,
	output logic      [PIN_COUNT-1:0]  pin_out,
	output logic      [PIN_COUNT-1:0]  pin_oe,
	// Status
	output logic      [IR_WIDTH-1:0]   instr,
	output logic                       extest_active
);

	scan_link_if link ();

	// Synchronisers
	logic                 tck_s1_reg;
	logic                 tck_s2_reg;
	logic                 tck_d_reg;
	logic                 tms_s1_reg;
	logic                 tms_s2_reg;
	logic                 tdi_s1_reg;
	logic                 tdi_s2_reg;
	logic                 trst_s1_reg;
	logic                 trst_s2_reg;
	logic [PIN_COUNT-1:0] pin_s1_reg;
	logic [PIN_COUNT-1:0] pin_s2_reg;

	// Controller state
	tap_state_t           state_reg;
	tap_state_t           state_next;
	logic [IR_WIDTH-1:0]  ir_shift_reg; // RL1
	logic [IR_WIDTH-1:0]  ir_reg;
	logic [ID_WIDTH-1:0]  id_shift_reg;
	logic                 bypass_reg;
	logic [2:0]           ones_reg;

	// Decoded terms
	wire                  tap_reset;
	wire                  tck_rise;
	wire                  tck_fall;
	wire                  in_shift;
	wire                  sel_bsr;
	wire                  sel_id;
	wire                  sel_bypass;
	wire                  dr_out;
	wire                  serial_out;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tck_s1_reg  <= 1'b0;
			tck_s2_reg  <= 1'b0;
			tck_d_reg   <= 1'b0;
			tms_s1_reg  <= 1'b1;
			tms_s2_reg  <= 1'b1;
			tdi_s1_reg  <= 1'b1;
			tdi_s2_reg  <= 1'b1;
			trst_s1_reg <= 1'b1;
			trst_s2_reg <= 1'b1;
			pin_s1_reg  <= '0;
			pin_s2_reg  <= '0;
		end else begin
			tck_s1_reg  <= tck;
			tck_s2_reg  <= tck_s1_reg;
			tck_d_reg   <= tck_s2_reg;
			tms_s1_reg  <= tms;
			tms_s2_reg  <= tms_s1_reg;
			tdi_s1_reg  <= tdi;
			tdi_s2_reg  <= tdi_s1_reg;
			trst_s1_reg <= trst_n;
			trst_s2_reg <= trst_s1_reg;
			pin_s1_reg  <= pin_in;
			pin_s2_reg  <= pin_s1_reg;
		end
	end

	// Test reset needs no test clock edge, only sys_clk
	assign tap_reset = reset || !trst_s2_reg; // RL2
	assign tck_rise  = tck_s2_reg && !tck_d_reg; // RL3
	assign tck_fall  = !tck_s2_reg && tck_d_reg; // RL4

	always_comb begin
		state_next = state_reg;
		case (state_reg) // RL14
			TEST_LOGIC_RESET: state_next = tms_s2_reg ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE:    state_next = tms_s2_reg ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR:        state_next = tms_s2_reg ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR:       state_next = tms_s2_reg ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR:         state_next = tms_s2_reg ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR:         state_next = tms_s2_reg ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR:         state_next = tms_s2_reg ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR:         state_next = tms_s2_reg ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR:        state_next = tms_s2_reg ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR:        state_next = tms_s2_reg ? TEST_LOGIC_RESET : CAPTURE_IR; // RL8
			CAPTURE_IR:       state_next = tms_s2_reg ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR:         state_next = tms_s2_reg ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR:         state_next = tms_s2_reg ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR:         state_next = tms_s2_reg ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR:         state_next = tms_s2_reg ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR:        state_next = tms_s2_reg ? SELECT_DR : RUN_TEST_IDLE;
			default:          state_next = TEST_LOGIC_RESET;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			state_reg <= TEST_LOGIC_RESET; // RL2
		end else if (tck_rise) begin
			state_reg <= state_next; // RL7
		end
	end

	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			ir_shift_reg <= IR_CAPTURE_VAL;
		end else if (tck_rise && state_reg == CAPTURE_IR) begin
			ir_shift_reg <= IR_CAPTURE_VAL;
		end else if (tck_rise && state_reg == SHIFT_IR) begin
			ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[IR_WIDTH-1:1]}; // RL6
		end
	end

	// Instruction changes only here, so a partial shift never decodes
	always_ff @(posedge sys_clk) begin
		if (tap_reset || state_reg == TEST_LOGIC_RESET) begin
			ir_reg <= IR_RESET_VAL;
		end else if (tck_fall && state_reg == UPDATE_IR) begin
			ir_reg <= ir_shift_reg; // RL12
		end
	end

	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			id_shift_reg <= ID_VALUE;
		end else if (tck_rise && sel_id && state_reg == CAPTURE_DR) begin
			id_shift_reg <= ID_VALUE; // RL11
		end else if (tck_rise && sel_id && state_reg == SHIFT_DR) begin
			id_shift_reg <= {tdi_s2_reg, id_shift_reg[ID_WIDTH-1:1]}; // RL6
		end
	end

	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && sel_bypass && state_reg == CAPTURE_DR) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && sel_bypass && state_reg == SHIFT_DR) begin
			bypass_reg <= tdi_s2_reg; // RL6
		end
	end

	// Unknown opcodes fall back to bypass
	assign sel_bsr    = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE); // RL13
	assign sel_id     = (ir_reg == IR_IDCODE); // RL13
	assign sel_bypass = !sel_bsr && !sel_id; // RL13
	assign dr_out     = sel_bsr ? link.bsr_tdo : (sel_id ? id_shift_reg[0] : bypass_reg);
	assign serial_out = (state_reg == SHIFT_IR) ? ir_shift_reg[0] : dr_out;
	assign in_shift   = (state_reg == SHIFT_DR) || (state_reg == SHIFT_IR); // RL5

	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo    <= serial_out; // RL4
			tdo_oe <= in_shift; // RL5
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			instr         <= IR_RESET_VAL;
			extest_active <= 1'b0;
		end else begin
			instr         <= ir_reg;
			extest_active <= (ir_reg == IR_EXTEST);
		end
	end

	// Run of high mode-select samples, for the reset check
	always_ff @(posedge sys_clk) begin
		if (tap_reset) begin
			ones_reg <= '0;
		end else if (tck_rise) begin
			ones_reg <= !tms_s2_reg ? 3'h0 :
				(ones_reg == TLR_TMS_COUNT) ? ones_reg : ones_reg + 3'h1;
		end
	end

	assign link.tck_rise    = tck_rise;
	assign link.tck_fall    = tck_fall;
	assign link.tdi         = tdi_s2_reg;
	assign link.capture_dr  = (state_reg == CAPTURE_DR);
	assign link.shift_dr    = (state_reg == SHIFT_DR);
	assign link.update_dr   = (state_reg == UPDATE_DR);
	assign link.logic_reset = tap_reset || (state_reg == TEST_LOGIC_RESET);
	assign link.bsr_sel     = sel_bsr;
	assign link.extest      = (ir_reg == IR_EXTEST);

	boundary_cell_chain u_chain (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.link     (link),
		.pin_in_s (pin_s2_reg),
		.core_out (core_out),
		.core_oe  (core_oe),
		.pin_out  (pin_out),
		.pin_oe   (pin_oe)
	);

	AST_TMS_FIVE_RESET: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL8
		ones_reg == TLR_TMS_COUNT |-> state_reg == TEST_LOGIC_RESET)
		else $error("Five high mode samples did not reach reset");

	AST_TRST_RESET: assert property (@(posedge sys_clk) disable iff (reset) // RL2
		!trst_s2_reg |=> state_reg == TEST_LOGIC_RESET && ir_reg == IR_RESET_VAL)
		else $error("Test reset did not reset the controller");

	AST_STATE_ON_EDGE: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL7
		!tck_rise |=> $stable(state_reg))
		else $error("State moved without a rising test clock edge");

	AST_SAMPLE_RISE: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL3
		tck_rise && state_reg == RUN_TEST_IDLE |=>
		state_reg == ($past(tms_s2_reg) ? SELECT_DR : RUN_TEST_IDLE))
		else $error("Mode select not applied at the rising edge");

	AST_GRAPH_IR: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL14
		tck_rise && state_reg == SELECT_IR && tms_s2_reg |=> state_reg == TEST_LOGIC_RESET)
		else $error("Select-IR with mode high did not go to reset");

	AST_TDO_DRIVEN: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL5
		tck_fall && in_shift |=> tdo_oe ##1 tdo_oe)
		else $error("Serial output not driven while shifting");

	AST_TDO_RELEASED: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL5
		tck_fall && !in_shift |=> !tdo_oe)
		else $error("Serial output driven outside shift states");

	AST_TDO_FALL_ONLY: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL4
		!tck_fall |=> $stable(tdo))
		else $error("Serial output changed away from a falling edge");

	AST_IR_UPDATE_ONLY: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL12
		!$stable(ir_reg) |-> $past(state_reg) == UPDATE_IR || state_reg == TEST_LOGIC_RESET)
		else $error("Instruction changed outside Update-IR");

	AST_BYPASS_ONE_BIT: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL13
		tck_fall && sel_bypass && state_reg == SHIFT_DR |=> tdo == $past(bypass_reg))
		else $error("Bypass path not on serial output");

	AST_ID_CAPTURE: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL11
		tck_rise && sel_id && state_reg == CAPTURE_DR |=> id_shift_reg == ID_VALUE)
		else $error("Identification value not captured");

	AST_IR_SIX_BITS: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL1
		tck_rise && state_reg == CAPTURE_IR |=> ir_shift_reg == IR_CAPTURE_VAL)
		else $error("Instruction capture value wrong");

	// Shifted word lands whole, never a partial one
	AST_IR_LOAD: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL12
		tck_fall && state_reg == UPDATE_IR |=> ir_reg == $past(ir_shift_reg))
		else $error("Instruction not loaded at Update-IR");

	AST_TLR_IR: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL12
		state_reg == TEST_LOGIC_RESET |=> ir_reg == IR_RESET_VAL)
		else $error("Instruction not reset in Test-Logic-Reset");

	AST_ID_SHIFT_OUT: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL13
		tck_fall && sel_id && state_reg == SHIFT_DR |=> tdo == $past(id_shift_reg[0]))
		else $error("Identification bit not on serial output");

	AST_IR_SHIFT_OUT: assert property (@(posedge sys_clk) disable iff (tap_reset) // RL4
		tck_fall && state_reg == SHIFT_IR |=> tdo == $past(ir_shift_reg[0]))
		else $error("Instruction bit not on serial output");

	COV_IR_UPDATE: cover property (@(posedge sys_clk) disable iff (tap_reset)
		tck_fall && state_reg == UPDATE_IR);
	COV_ID_SHIFT: cover property (@(posedge sys_clk) disable iff (tap_reset)
		tck_fall && sel_id && state_reg == SHIFT_DR);
	COV_EXTEST: cover property (@(posedge sys_clk) disable iff (tap_reset)
		link.extest && tck_fall && state_reg == UPDATE_DR);
	COV_TMS_RESET: cover property (@(posedge sys_clk) disable iff (tap_reset)
		ones_reg == TLR_TMS_COUNT);
	COV_PAUSE_DR: cover property (@(posedge sys_clk) disable iff (tap_reset)
		tck_rise && state_reg == PAUSE_DR);

endmodule : jtag_tap_boundary_scan

`default_nettype wire

// ---- logic/jtag_pkg.sv ----
// Purpose: Shared constants and types for the test access port.
// Assumes: Sampling clock runs far faster than the test clock.
// Notes: Opcode values and identification value are local choices.
//
// Notes on behaviour
// RL1: Sixteen-state controller, six-bit instruction register, five test pins.
// RL2: Low test reset puts controller in reset, needing no test clock edges.
// RL3: Mode select and serial input sampled on every rising test clock edge.
// RL4: Serial output changes on falling test clock edge for capture on next rise.
// RL5: Serial output driven only in the two shift states, else released.
// RL6: One serial input feeds boundary, instruction, identification and bypass.
// RL7: State moves only by mode select sampled at rising test clock edges.
// RL8: Five rising edges with mode select high reach the reset state.
// RL9: Boundary chain covers the DC-coupled pins for interconnect testing.
// RL10: No AC-coupled test mode; no time-varying test drive exists.
// RL11: An identification register can be shifted out to identify the part.
// RL12: New instruction takes effect only while passing Update-IR.
// RL13: Bypass, boundary and identification registers sit in parallel, selected.
// RL14: Transitions follow the standard sixteen-state controller graph.

package jtag_pkg;

	localparam int          IR_WIDTH       = 6;
	localparam int          ID_WIDTH       = 32;
	localparam int          PIN_COUNT      = 8;
	localparam int          CELLS_PER_PIN  = 3;
	localparam int          BSR_LEN        = PIN_COUNT * CELLS_PER_PIN;

	localparam logic [5:0]  IR_EXTEST      = 6'h00;
	localparam logic [5:0]  IR_SAMPLE      = 6'h01;
	localparam logic [5:0]  IR_IDCODE      = 6'h02;
	localparam logic [5:0]  IR_BYPASS      = 6'h3f;
	localparam logic [5:0]  IR_CAPTURE_VAL = 6'h01;
	localparam logic [5:0]  IR_RESET_VAL   = IR_IDCODE;

	// Arbitrary identification value; bit 0 must stay one
	localparam logic [31:0] ID_VALUE       = 32'h0000_1001;

	localparam logic [2:0]  TLR_TMS_COUNT  = 3'h5;

	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_TEST_IDLE,
		SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
		SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
	} tap_state_t;

endpackage : jtag_pkg

// ---- logic/scan_link_if.sv ----
// Purpose: Carries controller strobes to the boundary cell chain.
// Assumes: All signals live on sys_clk.
// Notes: Edge strobes tck_rise and tck_fall are one sys_clk cycle wide.
`timescale 1ns/1ps
`default_nettype none

interface scan_link_if;
	logic tck_rise;
	logic tck_fall;
	logic tdi;
	logic capture_dr;
	logic shift_dr;
	logic update_dr;
	logic logic_reset;
	logic bsr_sel;
	logic extest;
	logic bsr_tdo;

	modport tap (output tck_rise, tck_fall, tdi, capture_dr, shift_dr, update_dr,
		logic_reset, bsr_sel, extest, input bsr_tdo);
	modport chain (input tck_rise, tck_fall, tdi, capture_dr, shift_dr, update_dr,
		logic_reset, bsr_sel, extest, output bsr_tdo);
endinterface : scan_link_if

`default_nettype wire

// ---- logic/boundary_cell_chain.sv ----
// Purpose: Boundary register with capture, shift and update cells.
// Assumes: Pin inputs arrive already synchronised.
// Notes: Cells per pin: capture, output data, output enable.
`timescale 1ns/1ps
`default_nettype none

module boundary_cell_chain
	import jtag_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Controller side
	scan_link_if.chain                 link,
	// Core and pad side
	input  wire logic [PIN_COUNT-1:0]  pin_in_s,
	input  wire logic [PIN_COUNT-1:0]  core_out,
	input  wire logic [PIN_COUNT-1:0]  core_oe,
	output logic      [PIN_COUNT-1:0]  pin_out,
	output logic      [PIN_COUNT-1:0]  pin_oe
);

	logic [BSR_LEN-1:0]   shift_reg;
	logic [BSR_LEN-1:0]   update_reg;
	logic [BSR_LEN-1:0]   capture_val;
	logic [PIN_COUNT-1:0] upd_data;
	logic [PIN_COUNT-1:0] upd_en;

	genvar i;
	generate
		for (i = 0; i < PIN_COUNT; i++) begin : g_pin
			// Capture sees core data only while the core drives the pad
			assign capture_val[CELLS_PER_PIN*i]   = (core_oe[i] && !link.extest) ?
				core_out[i] : pin_in_s[i]; // RL9
			assign capture_val[CELLS_PER_PIN*i+1] = core_out[i];
			assign capture_val[CELLS_PER_PIN*i+2] = core_oe[i];
			assign upd_data[i] = update_reg[CELLS_PER_PIN*i+1];
			assign upd_en[i]   = update_reg[CELLS_PER_PIN*i+2];
		end
	endgenerate

	assign link.bsr_tdo = shift_reg[0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shift_reg <= '0;
		end else if (link.tck_rise && link.bsr_sel && link.capture_dr) begin
			shift_reg <= capture_val; // RL9
		end else if (link.tck_rise && link.bsr_sel && link.shift_dr) begin
			shift_reg <= {link.tdi, shift_reg[BSR_LEN-1:1]}; // RL6
		end
	end

	// Falling-edge update keeps skew from corrupting the latched value
	always_ff @(posedge sys_clk) begin
		if (reset || link.logic_reset) begin
			update_reg <= '0;
		end else if (link.tck_fall && link.bsr_sel && link.update_dr) begin
			update_reg <= shift_reg;
		end
	end

	// Static levels only: there is no pulsed AC test drive
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			pin_out <= link.extest ? upd_data : core_out; // RL10
			pin_oe  <= link.extest ? upd_en : core_oe; // RL9
		end
	end

	AST_PIN_FOLLOWS_CELL: assert property (@(posedge sys_clk) disable iff (reset) // RL9
		link.extest |=> pin_out == $past(upd_data))
		else $error("Pin drive does not follow boundary update cell");

	AST_NO_AC_DRIVE: assert property (@(posedge sys_clk) disable iff (reset) // RL10
		!link.extest ##1 (!link.extest && $stable(core_out)) |=> $stable(pin_out))
		else $error("Pin drive toggles without a cause");

endmodule : boundary_cell_chain

`default_nettype wire

// ---- tb/jtag_tester.sv ----
// Purpose: Behavioural board tester driving the test pins.
// Assumes: Caller sits just after a sys_clk rising edge.
// Notes: Test clock 80 ns, high 30 ns, idle low between frames.
`timescale 1ns/1ps
`default_nettype none

module jtag_tester (
	// Clock
	input  wire logic sys_clk,
	// Test pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo_pad
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
	end

	// Mode and data change at the fall, so they are settled long before the rise
	task automatic tick(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (5) @(posedge sys_clk);
		q = tdo_pad;
		tck <= 1'b1;
		repeat (3) @(posedge sys_clk);
		tck <= 1'b0;
	endtask : tick

	// Five ones reach reset from anywhere, then park in idle
	task automatic reset_seq();
		logic q;
		repeat (5) tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
	endtask : reset_seq

	// From idle to the exit state; the shifted data is not yet applied
	task automatic scan_to_exit(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b1, q);
		if (ir) tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tick(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
	endtask : scan_to_exit

	task automatic leave();
		logic q;
		tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
	endtask : leave

	task automatic pulse_trst();
		trst_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		trst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : pulse_trst
endmodule : jtag_tester

`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the test access port.
// Assumes: Tester model owns the test pins; bench owns core and pad side.
// Notes: Results queue up and a monitor compares them in order.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import jtag_pkg::*;
;

	typedef struct {
		logic [63:0] exp;
		logic [63:0] mask;
	} note_t;

	logic                 sys_clk = 1'b0;
	logic                 reset;
	logic                 tck, tms, tdi, trst_n, tdo, tdo_oe, extest_active, q, tdo_prev;
	wire                  tdo_pad;
	logic [PIN_COUNT-1:0] pin_in, core_out, core_oe, pin_out, pin_oe;
	logic [IR_WIDTH-1:0]  instr, cur, unk;
	logic [5:0]           ops [4];
	logic [63:0]          din, o, e, m, cap, pre;
	note_t                exp_q [$];
	note_t                cur_note;
	logic [63:0]          got_q [$];
	int                   n_mismatch = 0;
	int                   n_compared = 0;
	integer               seed = 82340;

	// Released pad floats, so a stray sample is never a match
	assign tdo_pad = tdo_oe ? tdo : 1'bz;

	always #5 sys_clk = ~sys_clk;

	jtag_tap_boundary_scan i_dut (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
		.core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe),
		.instr(instr), .extest_active(extest_active));

	jtag_tester i_tester (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo_pad(tdo_pad));

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic note(input logic [63:0] got, input logic [63:0] exp, input logic [63:0] msk);
		exp_q.push_back('{exp, msk});
		got_q.push_back(got);
	endtask : note

	function automatic logic [PIN_COUNT-1:0] pick(input logic [63:0] v, input int off);
		logic [PIN_COUNT-1:0] r;
		for (int i = 0; i < PIN_COUNT; i++) r[i] = v[CELLS_PER_PIN * i + off];
		return r;
	endfunction : pick

	task automatic ir_load(input logic [5:0] op);
		i_tester.scan_to_exit(1'b1, IR_WIDTH, {58'h0, op}, o);
		note(o, {58'h0, IR_CAPTURE_VAL}, 64'h3f);
		note({58'h0, instr}, {58'h0, cur}, 64'h3f);
		i_tester.leave();
		repeat (6) @(posedge sys_clk);
		cur = op;
		note({58'h0, instr}, {58'h0, op}, 64'h3f);
		note({63'h0, tdo_oe}, 64'h0, 64'h1);
	endtask : ir_load

	task automatic dr_scan(input logic [63:0] ex, input logic [63:0] msk);
		i_tester.scan_to_exit(1'b0, 64, din, o);
		i_tester.leave();
		note(o, ex, msk);
	endtask : dr_scan

	// Capture cell of each pin sees pad input, or core data when core drives and ext is low
	task automatic build_cap(input logic ext);
		cap = '0;
		for (int i = 0; i < PIN_COUNT; i++)
			cap[CELLS_PER_PIN * i] = (core_oe[i] && !ext) ? core_out[i] : pin_in[i];
		e = (din << BSR_LEN) | cap;
		m = ({64{1'b1}} << BSR_LEN) | 64'h249249;
	endtask : build_cap

	initial forever begin
		wait (got_q.size() != 0);
		cur_note = exp_q.pop_front();
		check(got_q.pop_front() & cur_note.mask, cur_note.exp & cur_note.mask);
	end

	always @(posedge sys_clk) begin
		if (tdo_oe === 1'b1 && tdo !== tdo_prev) check({63'h0, tck}, 64'h0);
		tdo_prev <= tdo;
	end

	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		reset = 1'b1;
		pin_in = PIN_COUNT'($random(seed));
		core_out = PIN_COUNT'($random(seed));
		core_oe = PIN_COUNT'($random(seed));
		cur = IR_RESET_VAL;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		note({58'h0, instr}, {58'h0, IR_RESET_VAL}, 64'h3f);
		i_tester.reset_seq();
		unk = IR_WIDTH'($random(seed));
		if (unk inside {IR_EXTEST, IR_SAMPLE, IR_IDCODE, IR_BYPASS}) unk = 6'h2a;
		ops = '{IR_IDCODE, IR_BYPASS, unk, IR_SAMPLE};
		foreach (ops[k]) begin
			pin_in <= PIN_COUNT'($random(seed));
			core_out <= PIN_COUNT'($random(seed));
			core_oe <= PIN_COUNT'($random(seed));
			ir_load(ops[k]);
			din = {$random(seed), $random(seed)};
			build_cap(1'b0);
			if (ops[k] == IR_IDCODE) begin
				e = {din[31:0], ID_VALUE};
				m = '1;
			end else if (ops[k] != IR_SAMPLE) begin
				e = {din[62:0], 1'b0};
				m = '1;
			end
			dr_scan(e, m);
			note({48'h0, pin_oe, pin_out}, {48'h0, core_oe, core_out}, '1);
		end
		pre = din >> (64 - BSR_LEN);
		ir_load(IR_EXTEST);
		note({63'h0, extest_active}, 64'h1, 64'h1);
		core_out <= PIN_COUNT'($random(seed));
		repeat (4) @(posedge sys_clk);
		note({48'h0, pin_oe, pin_out}, {48'h0, pick(pre, 2), pick(pre, 1)}, '1);
		din = {$random(seed), $random(seed)};
		build_cap(1'b1);
		dr_scan(e, m);
		pre = din >> (64 - BSR_LEN);
		repeat (4) @(posedge sys_clk);
		note({48'h0, pin_oe, pin_out}, {48'h0, pick(pre, 2), pick(pre, 1)}, '1);
		i_tester.tick(1'b1, 1'b1, q);
		i_tester.tick(1'b0, 1'b0, q);
		repeat (4) i_tester.tick(1'b0, 1'b0, q);
		// Pause inside the frame releases the output, resuming drives it again
		i_tester.tick(1'b1, 1'b0, q);
		i_tester.tick(1'b0, 1'b0, q);
		repeat (4) @(posedge sys_clk);
		note({63'h0, tdo_oe}, 64'h0, 64'h1);
		i_tester.tick(1'b1, 1'b0, q);
		i_tester.tick(1'b0, 1'b0, q);
		repeat (4) @(posedge sys_clk);
		note({63'h0, tdo_oe}, 64'h1, 64'h1);
		i_tester.reset_seq();
		repeat (6) @(posedge sys_clk);
		note({57'h0, extest_active, instr}, {57'h0, 1'b0, IR_IDCODE}, '1);
		note({48'h0, pin_oe, pin_out}, {48'h0, core_oe, core_out}, '1);
		note({63'h0, tdo_oe}, 64'h0, 64'h1);
		cur = IR_IDCODE;
		ir_load(IR_BYPASS);
		i_tester.pulse_trst();
		note({58'h0, instr}, {58'h0, IR_IDCODE}, 64'h3f);
		i_tester.tick(1'b0, 1'b1, q);
		din = {$random(seed), $random(seed)};
		dr_scan({din[31:0], ID_VALUE}, '1);
		repeat (8) @(posedge sys_clk);
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
